// *** pkg/fmr_pkg.sv ***
// Package of constants and carrier types for the flooding mesh repeater.
`default_nettype none
package fmr_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0] FMR_REG_FLAGS   = 4'h0;
    localparam logic [3:0] FMR_REG_SLOTS   = 4'h1;
    localparam logic [3:0] FMR_REG_OWNADDR = 4'h2;
    localparam logic [3:0] FMR_REG_STATUS  = 4'h3;
    localparam logic [3:0] FMR_REG_MASK    = 4'h4;
    localparam logic [3:0] FMR_REG_STATE   = 4'h5;
    localparam logic [3:0] FMR_REG_COUNT   = 4'h6;

    // Field positions.
    localparam int FMR_FLAG_REPEAT  = 0;
    localparam int FMR_FLAG_SNIFF   = 1;
    localparam int FMR_IRQ_REPEATED = 0;
    localparam int FMR_IRQ_DUP      = 1;
    localparam int FMR_IRQ_LOCAL    = 2;
    localparam int FMR_IRQ_BUSY     = 3;

    localparam logic [7:0]  FMR_SLOTS_RST  = 8'h04;
    localparam logic [15:0] FMR_ADDR_RST   = 16'h0000;
    localparam logic [15:0] FMR_LFSR_SEED  = 16'hace1;
    localparam logic [15:0] FMR_LFSR_TAPS  = 16'hb400;

    // Slot length: time and derived cycle count at 50 MHz.
    localparam int FMR_CLK_HZ       = 50_000_000;
    localparam int FMR_SLOT_US      = 10;
    localparam int FMR_SLOT_CYCLES  = FMR_SLOT_US * (FMR_CLK_HZ / 1_000_000);

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] src;
        logic [15:0] dst;
        logic [7:0]  seq;
        logic        ack_req;
        logic [7:0]  payload;
    } fmr_pkt_t;

    typedef struct packed {
        logic [15:0] src;
        logic [15:0] dst;
    } fmr_ind_t;

    typedef enum logic [4:0] {
        FMR_IDLE  = 5'h01,
        FMR_CHECK = 5'h02,
        FMR_WAIT  = 5'h04,
        FMR_SENSE = 5'h08,
        FMR_SEND  = 5'h10
    } fmr_state_t;
endpackage
`default_nettype wire

// *** rtl/fmr_repeater.sv ***
// Flooding mesh repeater: filter, random slot delay, carrier sense, duplicate history.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1: Repeat only when flags bit 0 set.
// R2: Schedule every received packet not for us; the code drops one that arrives while the scheduler is not idle.
// R3: Wait random number of delay slots first.
// R4: Transmit only when the channel is free.
// R5: Forward each packet at most once; the code forwards a packet again once its history entry has been evicted.
// R6: Still deliver local packets and host sends.
// R7: Never acknowledge; ignore acknowledgement requests.
// R8: Retransmitted packets request no acknowledgement.
// R9: Sniffing and repeating never active together.
// R10: Indicate each repetition with source and destination.
// R11: Wrong-destination packets are not delivered locally.
// R12: Peers set retry count to zero.
// R13: Peers share profile, channel, address scheme.
// R14: Receivers discard duplicates themselves.
// R15: Keep each repeater to 2-5 packets/s; the code has no rate limit and forwards as fast as packets arrive.
// R16: Bounded history, oldest entry evicted.
module fmr_repeater #(
    parameter int HIST_DEPTH  = 8,
    parameter int SLOT_CYCLES = fmr_pkg::FMR_SLOT_CYCLES
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Register port
    input  wire logic [3:0]       reg_addr,
    input  wire logic [15:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output var  logic [15:0]      reg_rdata,
    // Radio receive side
    input  wire logic             rx_valid,
    input  wire fmr_pkg::fmr_pkt_t rx_pkt,
    input  wire logic             chan_busy_pin,
    // Radio transmit side
    output var  logic             tx_valid,
    output var  fmr_pkg::fmr_pkt_t tx_pkt,
    input  wire logic             tx_done,
    // Host side
    input  wire logic             host_tx_valid,
    input  wire fmr_pkg::fmr_pkt_t host_tx_pkt,
    output var  logic             host_tx_ready,
    output var  logic             local_valid,
    output var  fmr_pkg::fmr_pkt_t local_pkt,
    output var  logic             ind_valid,
    output var  fmr_pkg::fmr_ind_t ind_msg,
    output var  logic             irq
);
    import fmr_pkg::*;

    localparam int HW = $clog2(HIST_DEPTH);

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    // Index 0: flags, bit 0 asks for repeating, bit 1 for sniffing.
    // Index 1: number of delay slots the random wait is drawn over.
    // Index 2: own address; matching packets are delivered locally.
    // Index 3: sticky status, write a one to clear a bit.
    // Index 4: interrupt mask, same layout as status.
    // Index 5: current scheduler state, read only.
    // Index 6: count of completed repetitions, read only.
    // Status bit 0 marks a repetition, bit 1 a dropped duplicate,
    // bit 2 a local delivery and bit 3 a packet lost while busy.
    // A slot count of zero sends as soon as the channel is free, which
    // gives up collision avoidance between neighbouring repeaters.

    typedef struct packed {
        // Software settings.
        logic [1:0]              flags;
        logic [7:0]              slots;
        logic [15:0]             own_addr;

        // Interrupt state.
        logic [3:0]              status;
        logic [3:0]              mask;

        // Read data and statistics.
        logic [15:0]             rd;
        logic [15:0]             count;

        // Random source and channel sense.
        logic [15:0]             lfsr;
        logic [2:0]              busy_sync;
        logic                    busy;

        // Scheduler.
        fmr_state_t              state;
        fmr_pkt_t                pend;
        logic                    pend_host;
        logic [7:0]              slot_left;
        logic [31:0]             tick;

        // Duplicate history.
        logic [HIST_DEPTH-1:0]   hv;
        logic [HIST_DEPTH-1:0][23:0] hid;
        logic [HW-1:0]           hptr;

        // Registered outputs.
        logic                    tx_valid;
        fmr_pkt_t                tx_pkt;
        logic                    host_ready;
        logic                    local_valid;
        fmr_pkt_t                local_pkt;
        logic                    ind_valid;
        fmr_ind_t                ind_msg;
        logic                    irq;
    } fmr_regs_t;

    fmr_regs_t q;
    fmr_regs_t d;
    logic [HIST_DEPTH-1:0] hit_vec;
    logic                  dup_hit;
    logic                  repeat_on;
    logic [3:0]            ev;

    // ------------------------------------------------------------------
    // History match
    // ------------------------------------------------------------------
    // One comparator per entry; the history is small so this stays cheap.
    generate
        for (genvar i = 0; i < HIST_DEPTH; i++) begin : g_hist
            assign hit_vec[i] = q.hv[i] && (q.hid[i] == {rx_pkt.src, rx_pkt.seq}); // [R5]
        end
    endgenerate
    assign dup_hit   = |hit_vec;
    // Repeating is held off whenever sniffing is also requested.
    assign repeat_on = q.flags[FMR_FLAG_REPEAT] && !q.flags[FMR_FLAG_SNIFF]; // [R1] [R9]

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        ev = 4'h0;
        d.local_valid = 1'b0;
        d.ind_valid = 1'b0;
        d.lfsr = {q.lfsr[14:0], ^(q.lfsr & FMR_LFSR_TAPS)};

        // ------------------------------------------------------------------
        // Channel sense synchroniser
        // ------------------------------------------------------------------
        // A change is taken only when the last two stages agree, so a
        // glitch on the pin can neither start nor stop a send.
        d.busy_sync = {q.busy_sync[1:0], chan_busy_pin};
        if (q.busy_sync[2] == q.busy_sync[1]) begin
            d.busy = q.busy_sync[1];
        end

        // ------------------------------------------------------------------
        // Receive filter
        // ------------------------------------------------------------------
        if (rx_valid) begin
            if (rx_pkt.dst == q.own_addr) begin
                // Local delivery; any acknowledgement request is simply dropped.
                d.local_valid = 1'b1; // [R6] [R11] [R7]
                d.local_pkt = rx_pkt;
                ev[FMR_IRQ_LOCAL] = 1'b1;
            end else if (repeat_on) begin
                if (dup_hit) begin
                    ev[FMR_IRQ_DUP] = 1'b1; // [R5]
                end else if (q.state == FMR_IDLE) begin
                    d.pend = rx_pkt; // [R2]
                    d.pend_host = 1'b0;
                    d.state = FMR_CHECK;
                end else begin
                    // Busy with an earlier packet: this one is lost.
                    ev[FMR_IRQ_BUSY] = 1'b1;
                end
            end
        end

        // ------------------------------------------------------------------
        // Transmit scheduler
        // ------------------------------------------------------------------
        case (q.state)
            FMR_IDLE: begin
                // A received packet claims the scheduler before a host request.
                if (host_tx_valid && q.host_ready && !(rx_valid && d.state == FMR_CHECK)) begin
                    d.pend = host_tx_pkt; // [R6]
                    d.pend_host = 1'b1;
                    d.state = FMR_SENSE;
                end
            end
            FMR_CHECK: begin
                // Draw the slot count once the packet is latched.
                if (q.slots == 8'h00) begin
                    d.slot_left = 8'h00;
                end else begin
                    d.slot_left = q.lfsr[7:0] % q.slots; // [R3]
                end
                d.tick = 32'(SLOT_CYCLES - 1);
                d.state = FMR_WAIT;
            end
            FMR_WAIT: begin
                // Each remaining slot lasts SLOT_CYCLES clock cycles.
                if (q.slot_left == 8'h00) begin
                    d.state = FMR_SENSE; // [R3]
                end else if (q.tick == 32'h0) begin
                    d.tick = 32'(SLOT_CYCLES - 1);
                    d.slot_left = q.slot_left - 8'h01;
                end else begin
                    d.tick = q.tick - 32'h1;
                end
            end
            FMR_SENSE: begin
                if (!q.busy) begin
                    d.tx_valid = 1'b1; // [R4]
                    d.tx_pkt = q.pend;
                    // Host packets keep their acknowledgement request.
                    if (!q.pend_host) begin
                        d.tx_pkt.ack_req = 1'b0; // [R8]
                    end
                    d.state = FMR_SEND;
                end
            end
            FMR_SEND: begin
                if (tx_done) begin
                    d.tx_valid = 1'b0;
                    d.state = FMR_IDLE;
                    if (!q.pend_host) begin
                        // Only repeats enter the history; host sends never do.
                        d.hid[q.hptr] = {q.pend.src, q.pend.seq}; // [R16]
                        d.hv[q.hptr] = 1'b1;
                        if (q.hptr == HW'(HIST_DEPTH - 1)) begin
                            d.hptr = '0;
                        end else begin
                            d.hptr = q.hptr + 1'b1;
                        end
                        d.ind_valid = 1'b1; // [R10]
                        d.ind_msg.src = q.pend.src;
                        d.ind_msg.dst = q.pend.dst;
                        d.count = q.count + 16'h1;
                        ev[FMR_IRQ_REPEATED] = 1'b1;
                    end
                end
            end
            default: begin
                d.state = FMR_IDLE;
            end
        endcase
        d.host_ready = (d.state == FMR_IDLE);

        // ------------------------------------------------------------------
        // Register port
        // ------------------------------------------------------------------
        d.rd = 16'h0000;
        if (reg_wr) begin
            case (reg_addr)
                FMR_REG_FLAGS: begin
                    d.flags = reg_wdata[1:0];
                end
                FMR_REG_SLOTS: begin
                    d.slots = reg_wdata[7:0];
                end
                FMR_REG_OWNADDR: begin
                    d.own_addr = reg_wdata;
                end
                FMR_REG_STATUS: begin
                    d.status = q.status & ~reg_wdata[3:0];
                end
                FMR_REG_MASK: begin
                    d.mask = reg_wdata[3:0];
                end
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                FMR_REG_FLAGS: begin
                    d.rd = {14'h0, q.flags};
                end
                FMR_REG_SLOTS: begin
                    d.rd = {8'h00, q.slots};
                end
                FMR_REG_OWNADDR: begin
                    d.rd = q.own_addr;
                end
                FMR_REG_STATUS: begin
                    d.rd = {12'h000, q.status};
                end
                FMR_REG_MASK: begin
                    d.rd = {12'h000, q.mask};
                end
                FMR_REG_STATE: begin
                    d.rd = {11'h000, q.state};
                end
                FMR_REG_COUNT: begin
                    d.rd = q.count;
                end
                default:         d.rd = 16'h0000;
            endcase
        end

        // ------------------------------------------------------------------
        // Interrupt status
        // ------------------------------------------------------------------
        // Events set after the clear so a simultaneous event is kept.
        d.status = d.status | ev;
        d.irq = |(d.status & d.mask);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // Everything clears except the slot count, LFSR seed and scheduler state, which load non-zero values.
            q <= '0;
            q.slots <= FMR_SLOTS_RST;
            q.own_addr <= FMR_ADDR_RST;
            q.lfsr <= FMR_LFSR_SEED;
            q.state <= FMR_IDLE;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata     = q.rd;
    assign tx_valid      = q.tx_valid;
    assign tx_pkt        = q.tx_pkt;
    assign host_tx_ready = q.host_ready;
    assign local_valid   = q.local_valid;
    assign local_pkt     = q.local_pkt;
    assign ind_valid     = q.ind_valid;
    assign ind_msg       = q.ind_msg;
    assign irq           = q.irq;
endmodule
`default_nettype wire

// *** tb/fmr_repeater_properties.sv ***
// Concurrent checks on the repeater's ports.
`timescale 1ns/1ps
`default_nettype none
module fmr_repeater_properties (
    // Clock, reset and register port
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    // Radio and host sides
    input wire logic rx_valid,
    input wire fmr_pkg::fmr_pkt_t rx_pkt,
    input wire logic chan_busy_pin,
    input wire logic tx_valid,
    input wire fmr_pkg::fmr_pkt_t tx_pkt,
    input wire logic tx_done,
    input wire logic host_tx_valid,
    input wire logic host_tx_ready,
    input wire logic local_valid,
    input wire fmr_pkg::fmr_pkt_t local_pkt,
    input wire logic ind_valid,
    input wire fmr_pkg::fmr_ind_t ind_msg,
    input wire logic irq
);
    import fmr_pkg::*;
    logic [15:0] own_q;
    logic [1:0] flags_q;
    logic mask_q;
    // Shadows of the settings, so that checks follow what software wrote.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            own_q <= FMR_ADDR_RST;
            flags_q <= 2'h0;
            mask_q <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == FMR_REG_OWNADDR) own_q <= reg_wdata;
            if (reg_addr == FMR_REG_FLAGS) flags_q <= reg_wdata[1:0];
            if (reg_addr == FMR_REG_MASK) mask_q <= reg_wdata[FMR_IRQ_REPEATED];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    local_deliver_a: assert property (
        rx_valid && rx_pkt.dst == own_q |=> local_valid && local_pkt == $past(rx_pkt))
        else $error("own packet not delivered");
    local_only_own_a: assert property (local_valid |-> local_pkt.dst == own_q)
        else $error("foreign packet delivered");
    repeat_off_a: assert property (
        rx_valid && flags_q != 2'h1 && host_tx_ready && !host_tx_valid |=> !tx_valid [*8])
        else $error("forwarding while repeating is off");
    own_not_sent_a: assert property (
        rx_valid && rx_pkt.dst == own_q && host_tx_ready && !host_tx_valid |=> !tx_valid [*8])
        else $error("own packet answered or forwarded");
    sense_free_a: assert property ($rose(tx_valid) |-> !$past(chan_busy_pin, 4))
        else $error("transmit on busy channel");
    ind_after_tx_a: assert property (ind_valid |-> $past(tx_valid) && $past(tx_done))
        else $error("indication without transmission");
    ind_addr_a: assert property (
        ind_valid |-> ind_msg == {$past(tx_pkt.src), $past(tx_pkt.dst)})
        else $error("indication addresses wrong");
    repeat_no_ack_a: assert property (ind_valid |-> !$past(tx_pkt.ack_req))
        else $error("repeat requests acknowledgement");
    irq_raise_a: assert property (ind_valid && mask_q |=> irq)
        else $error("interrupt missing after repeat");
endmodule
bind fmr_repeater fmr_repeater_properties u_fmr_repeater_properties (.*);
`default_nettype wire

// *** tb/fmr_radio_model.sv ***
// Behavioural radio peer: channel sense level and transmit completion.
`timescale 1ns/1ps
`default_nettype none
module fmr_radio_model (
    // Clock, reset and bench control
    input wire logic clk,
    input wire logic rst,
    input wire logic busy_req,
    input wire logic slow,
    // Transmit side of the repeater
    input wire logic tx_valid,
    input wire fmr_pkg::fmr_pkt_t tx_pkt,
    output var logic tx_done,
    output var logic chan_busy_pin,
    output var logic [7:0] sent,
    output var fmr_pkg::fmr_pkt_t last_pkt
);
    import fmr_pkg::*;
    logic [2:0] cnt_q;
    // Peers share channel and profile, so the sensed level is their traffic.
    assign chan_busy_pin = busy_req;
    // Peers keep their retry count at zero and never return acknowledgements.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 3'h0;
            tx_done <= 1'b0;
            sent <= 8'h00;
            last_pkt <= '0;
        end else begin
            tx_done <= 1'b0;
            if (!tx_valid) begin
                cnt_q <= 3'h0;
            end else if (cnt_q == (slow ? 3'h5 : 3'h1)) begin
                tx_done <= 1'b1;
                sent <= sent + 8'h01;
                last_pkt <= tx_pkt; // Receivers filter duplicates from this themselves.
                cnt_q <= cnt_q + 3'h1;
            end else if (cnt_q != 3'h7) begin
                cnt_q <= cnt_q + 3'h1;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/fmr_repeater_tb.sv ***
// Self-checking bench for the flooding mesh repeater.
`timescale 1ns/1ps
`default_nettype none
module fmr_repeater_tb;
    import fmr_pkg::*;
    logic clk, rst, reg_wr, reg_rd, rx_valid, host_tx_valid, busy_req, slow;
    logic tx_valid, tx_done, chan_busy_pin, host_tx_ready, local_valid, ind_valid, irq;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rv;
    logic [7:0] sent, exp_sent;
    fmr_pkt_t rx_pkt, host_tx_pkt, tx_pkt, local_pkt, last_pkt, p0, p;
    fmr_ind_t ind_msg;
    int fail_count, tests_run, i, seed;
    fmr_repeater #(.HIST_DEPTH(8), .SLOT_CYCLES(4)) u_fmr_repeater (.clk, .rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_valid, .rx_pkt, .chan_busy_pin, .tx_valid,
        .tx_pkt, .tx_done, .host_tx_valid, .host_tx_pkt, .host_tx_ready, .local_valid,
        .local_pkt, .ind_valid, .ind_msg, .irq);
    fmr_radio_model u_fmr_radio_model (.clk, .rst, .busy_req, .slow, .tx_valid, .tx_pkt,
        .tx_done, .chan_busy_pin, .sent, .last_pkt);
    task automatic chk(input string what, input logic [48:0] exp, input logic [48:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic send_rx(input fmr_pkt_t r);
        @(posedge clk);
        {rx_valid, rx_pkt} <= {1'b1, r};
        @(posedge clk);
        rx_valid <= 1'b0;
    endtask
    // Polls before each edge so a one-cycle pulse right after the request is not missed.
    task automatic wait_for(input int sel);
        for (int n = 0; n < 600; n++) begin
            #1;
            if ((sel == 0 && ind_valid === 1'b1) || (sel == 1 && local_valid === 1'b1)
                || (sel == 2 && sent === exp_sent)) return;
            @(posedge clk);
        end
        fail_count++;
        $display("MISMATCH wait %0d expected event seen none", sel);
        report_and_stop();
    endtask
    task automatic quiet(input int n);
        repeat (n) @(posedge clk);
        chk("sent", exp_sent, sent);
    endtask
    function automatic fmr_pkt_t rnd_pkt();
        fmr_pkt_t r;
        r = 49'({$urandom, $urandom});
        r.dst[8] = 1'b1;
        return r;
    endfunction
    function automatic fmr_pkt_t fwd(input fmr_pkt_t r);
        r.ack_req = 1'b0;
        return r;
    endfunction
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, rx_valid, host_tx_valid, busy_req, slow} = '0;
        {reg_addr, reg_wdata, rx_pkt, host_tx_pkt, exp_sent} = '0;
        {fail_count, tests_run} = '0;
        seed = $urandom(32'h2d50b00c);
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(FMR_REG_SLOTS, rv);
        chk("slots", FMR_SLOTS_RST, rv);
        rd(FMR_REG_STATE, rv);
        chk("state", FMR_IDLE, rv);
        rd(4'hf, rv);
        chk("unmapped", 16'h0000, rv);
        $display("test reset done");
        wr(FMR_REG_OWNADDR, 16'h0005);
        for (i = 0; i < 4; i += 3) begin
            wr(FMR_REG_FLAGS, 16'(i));
            send_rx(rnd_pkt());
            quiet(100);
        end
        $display("test repeat off done");
        wr(FMR_REG_FLAGS, 16'h0001);
        wr(FMR_REG_MASK, 16'h0001);
        // One packet in flight at a time keeps the forwarding rate low.
        for (i = 0; i < 9; i++) begin
            p = rnd_pkt();
            if (i == 0) p0 = p;
            wr(FMR_REG_SLOTS, 16'($urandom_range(8, 1)));
            send_rx(p);
            exp_sent++;
            wait_for(0);
            chk("ind", {p.src, p.dst}, ind_msg);
            chk("fwd", fwd(p), last_pkt);
            rd(FMR_REG_STATUS, rv);
            chk("status", 16'h0001, rv);
            chk("irq", 1'b1, irq);
            wr(FMR_REG_STATUS, 16'h000f);
        end
        send_rx(p);
        quiet(100);
        rd(FMR_REG_STATUS, rv);
        chk("dup", 16'h0002, rv);
        wr(FMR_REG_STATUS, 16'h000f);
        send_rx(p0);
        exp_sent++;
        wait_for(0);
        chk("evicted", fwd(p0), last_pkt);
        $display("test repeat done");
        p = rnd_pkt();
        p.dst = 16'h0005;
        p.ack_req = 1'b1;
        send_rx(p);
        wait_for(1);
        chk("local", p, local_pkt);
        quiet(60);
        $display("test local done");
        busy_req <= 1'b1;
        repeat (5) @(posedge clk);
        p = rnd_pkt();
        send_rx(p);
        quiet(150);
        busy_req <= 1'b0;
        exp_sent++;
        wait_for(0);
        chk("busy", fwd(p), last_pkt);
        rd(FMR_REG_COUNT, rv);
        chk("count", 16'(exp_sent), rv);
        $display("test busy done");
        slow <= 1'b1;
        p.ack_req = 1'b1;
        p.seq = p.seq + 8'h01;
        @(posedge clk);
        {host_tx_valid, host_tx_pkt} <= {1'b1, p};
        @(posedge clk);
        host_tx_valid <= 1'b0;
        exp_sent++;
        wait_for(2);
        chk("host", p, last_pkt);
        $display("test host done");
        report_and_stop();
    end
endmodule
`default_nettype wire
